// *** vdpao_top.sv ***
// voice dac data path and pwm speaker driver with register port
// Functional notes
// [R1] bit 1 of the modulator control register switches the dac path on when one and off when zero.
// [R2] with the dac disabled the dac output is marked invalid and carries no level.
// [R3] the 12-bit dac sample is the high register above the upper nibble of the low register.
// [R4] reads of the dac low register return zero in bits 0 to 3.
// [R5] the low three volume bits give eight monotonic dac levels, 111 loudest and 000 quietest.
// [R6] there is exactly one 12-bit pwm generator able to drive a speaker directly.
// [R7] in differential mode with the sign bit clear the first speaker pin pulses and the second is held at ground.
// [R8] with the single-ended bit set only the first speaker pin carries the signal.
// [R9] while running with the single-ended bit clear the sign bit picks which pin is held at ground and which pulses.
// [R10] after reset both speaker pins stay low until the generator is first started.
// [R11] whenever the generator is stopped both speaker pins are low.
// [R12] a rise of the run bit starts the generator and latches the pwm data registers.
// [R13] without new data the previously latched duty keeps being used.
// [R14] a fall of the run bit lets the current period finish before the outputs stop.
// [R15] a 4-bit volume scales the pwm, any 1xxx loudest, 0111 down to 0000 quieter.
// [R16] pulses come from a 12-bit free-running counter compared with the latched duty.
`timescale 1ns/10ps
module vdpao_top
    import vdpao_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output      logic [7:0]  RDATA,
    output      logic [11:0] DAC_LEVEL,
    output      logic        DAC_VALID,
    output      logic        SPEAKER_OUT_FIRST,
    output      logic        SPEAKER_OUT_SECOND
);

    // =====================================================================
    // register file
    logic [7:0] dac_data_low_q, dac_data_low_d;
    logic [7:0] dac_data_high_q, dac_data_high_d;
    logic [7:0] volume_setting_q, volume_setting_d;
    logic [7:0] pwm_data_low_q, pwm_data_low_d;
    logic [7:0] pwm_data_high_q, pwm_data_high_d;
    logic [7:0] modulator_control_reg_q, modulator_control_reg_d;
    logic [7:0] rdata_d;

    vdpao_pwm_cmd_t  pwm_cmd;
    vdpao_pwm_stat_t pwm_stat;

    always_comb begin
        dac_data_low_d          = dac_data_low_q;
        dac_data_high_d         = dac_data_high_q;
        volume_setting_d        = volume_setting_q;
        pwm_data_low_d          = pwm_data_low_q;
        pwm_data_high_d         = pwm_data_high_q;
        modulator_control_reg_d = modulator_control_reg_q;
        if (WR) begin
            unique case (ADDR)
                // bits 0..3 are never stored, so they can only read back zero
                VDPAO_OFF_DAC_LOW:  dac_data_low_d   = WDATA & VDPAO_LOW_NIBBLE_MASK; // see [R4]
                VDPAO_OFF_DAC_HIGH: dac_data_high_d  = WDATA;
                VDPAO_OFF_VOLUME:   volume_setting_d = WDATA;
                VDPAO_OFF_PWM_LOW:  pwm_data_low_d   = WDATA & VDPAO_LOW_NIBBLE_MASK;
                VDPAO_OFF_PWM_HIGH: pwm_data_high_d  = WDATA;
                VDPAO_OFF_CTRL:     modulator_control_reg_d = WDATA & VDPAO_CTRL_WMASK;
                default: begin
                end
            endcase
        end
        rdata_d = 8'h00;
        if (RD) begin
            unique case (ADDR)
                VDPAO_OFF_DAC_LOW:  rdata_d = dac_data_low_q;
                VDPAO_OFF_DAC_HIGH: rdata_d = dac_data_high_q;
                VDPAO_OFF_VOLUME:   rdata_d = volume_setting_q;
                VDPAO_OFF_PWM_LOW:  rdata_d = pwm_data_low_q;
                VDPAO_OFF_PWM_HIGH: rdata_d = pwm_data_high_q;
                VDPAO_OFF_CTRL: begin
                    rdata_d = modulator_control_reg_q;
                    rdata_d[VDPAO_CTRL_BUSY_BIT] = pwm_stat.active;
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            dac_data_low_q          <= VDPAO_REG_RESET;
            dac_data_high_q         <= VDPAO_REG_RESET;
            volume_setting_q        <= VDPAO_REG_RESET;
            pwm_data_low_q          <= VDPAO_REG_RESET;
            pwm_data_high_q         <= VDPAO_REG_RESET;
            modulator_control_reg_q <= VDPAO_REG_RESET;
            RDATA                   <= 8'h00;
        end else begin
            dac_data_low_q          <= dac_data_low_d;
            dac_data_high_q         <= dac_data_high_d;
            volume_setting_q        <= volume_setting_d;
            pwm_data_low_q          <= pwm_data_low_d;
            pwm_data_high_q         <= pwm_data_high_d;
            modulator_control_reg_q <= modulator_control_reg_d;
            RDATA                   <= rdata_d;
        end
    end

    // =====================================================================
    // dac data path
    logic        dac_enable;
    logic [11:0] dac_sample;
    logic [3:0]  dac_mult;
    logic [15:0] dac_prod;
    logic [11:0] dac_level_d;
    logic        dac_valid_d;

    always_comb begin
        dac_enable  = modulator_control_reg_q[VDPAO_CTRL_DAC_EN_BIT];     // see [R1]
        dac_sample  = {dac_data_high_q, dac_data_low_q[7:4]};             // see [R3]
        // (code+1)/8 of the sample, truncated: never falling, 111 passes the sample unchanged
        dac_mult    = {1'b0, volume_setting_q[2:0]} + 4'h1;               // see [R5]
        dac_prod    = 16'(dac_sample) * 16'(dac_mult);
        dac_level_d = dac_enable ? dac_prod[14:3] : 12'h000;              // see [R2]
        dac_valid_d = dac_enable;
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            DAC_LEVEL <= 12'h000;
            DAC_VALID <= 1'b0;
        end else begin
            DAC_LEVEL <= dac_level_d;
            DAC_VALID <= dac_valid_d;
        end
    end

    // =====================================================================
    // pwm generator, the only one in the block
    always_comb begin
        pwm_cmd.run    = modulator_control_reg_q[VDPAO_CTRL_RUN_BIT];
        pwm_cmd.duty   = {pwm_data_high_q, pwm_data_low_q[7:4]};
        pwm_cmd.volume = volume_setting_q[3:0];
    end

    vdpao_pwm_core u_pwm_core (                                           // see [R6]
        .clk   (CORE_CLK),
        .reset (RESET),
        .cmd   (pwm_cmd),
        .stat  (pwm_stat)
    );

    // =====================================================================
    // speaker pin steering
    logic single_sel;
    logic sign_sel;
    logic out_first_d;
    logic out_second_d;

    // sign-magnitude bridge: one pin pulses, its partner sits at ground
    always_comb begin
        single_sel   = modulator_control_reg_q[VDPAO_CTRL_SINGLE_BIT];
        sign_sel     = modulator_control_reg_q[VDPAO_CTRL_SIGN_BIT];
        out_first_d  = 1'b0;                                              // see [R11]
        out_second_d = 1'b0;
        if (pwm_stat.active) begin
            if (single_sel) begin
                out_first_d = pwm_stat.pulse;                             // see [R8]
            end else if (sign_sel) begin
                out_second_d = pwm_stat.pulse;                            // see [R9]
            end else begin
                out_first_d = pwm_stat.pulse;                             // see [R7]
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            SPEAKER_OUT_FIRST  <= 1'b0;                                   // see [R10]
            SPEAKER_OUT_SECOND <= 1'b0;
        end else begin
            SPEAKER_OUT_FIRST  <= out_first_d;
            SPEAKER_OUT_SECOND <= out_second_d;
        end
    end

    // =====================================================================
    // checks
    low_nibble_zero_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R4]
        RD && (ADDR == VDPAO_OFF_DAC_LOW) |=> (RDATA[3:0] == 4'h0))
        else $error("dac low register read nonzero low nibble");

    dac_enable_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R1]
        WR && (ADDR == VDPAO_OFF_CTRL) && WDATA[VDPAO_CTRL_DAC_EN_BIT] |=> ##1 DAC_VALID)
        else $error("dac not enabled after write of one");

    dac_off_invalid_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R2]
        !dac_enable |=> !DAC_VALID && (DAC_LEVEL == 12'h000))
        else $error("disabled dac shows a valid level");

    dac_loudest_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R3]
        dac_enable && (volume_setting_q[2:0] == 3'h7) |=> DAC_LEVEL == $past(dac_sample))
        else $error("dac level differs from sample at top volume");

    dac_monotonic_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R5]
        dac_enable && $stable(dac_sample) && (volume_setting_q[2:0] > $past(volume_setting_q[2:0]))
        |=> DAC_LEVEL >= $past(DAC_LEVEL))
        else $error("dac level fell while volume rose");

    stopped_low_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R11]
        !pwm_stat.active |=> !SPEAKER_OUT_FIRST && !SPEAKER_OUT_SECOND)
        else $error("speaker pins not low while stopped");

    single_end_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R8]
        pwm_stat.active && single_sel |=> !SPEAKER_OUT_SECOND && (SPEAKER_OUT_FIRST == $past(pwm_stat.pulse)))
        else $error("single-ended mode drove the second pin");

    sign_ground_a: assert property (@(posedge CORE_CLK) disable iff (RESET) // see [R9]
        pwm_stat.active && !single_sel |=>
        ($past(sign_sel) ? (!SPEAKER_OUT_FIRST && SPEAKER_OUT_SECOND == $past(pwm_stat.pulse))
                         : (!SPEAKER_OUT_SECOND && SPEAKER_OUT_FIRST == $past(pwm_stat.pulse))))
        else $error("sign bit did not steer the grounded pin");

endmodule // vdpao_top

// *** vdpao_pkg.sv ***
// shared constants and types for the voice dac and pwm audio output block
package vdpao_pkg;

    // =====================================================================
    // widths
    localparam int unsigned VDPAO_ADDR_W   = 3;
    localparam int unsigned VDPAO_DATA_W   = 8;
    localparam int unsigned VDPAO_SAMPLE_W = 12;

    // =====================================================================
    // register offsets
    localparam logic [2:0] VDPAO_OFF_DAC_LOW  = 3'h0;
    localparam logic [2:0] VDPAO_OFF_DAC_HIGH = 3'h1;
    localparam logic [2:0] VDPAO_OFF_VOLUME   = 3'h2;
    localparam logic [2:0] VDPAO_OFF_PWM_LOW  = 3'h3;
    localparam logic [2:0] VDPAO_OFF_PWM_HIGH = 3'h4;
    localparam logic [2:0] VDPAO_OFF_CTRL     = 3'h5;

    // =====================================================================
    // modulator_control_reg fields
    localparam int unsigned VDPAO_CTRL_RUN_BIT    = 0;
    localparam int unsigned VDPAO_CTRL_DAC_EN_BIT = 1;
    localparam int unsigned VDPAO_CTRL_SINGLE_BIT = 3;
    localparam int unsigned VDPAO_CTRL_SIGN_BIT   = 4;
    localparam int unsigned VDPAO_CTRL_BUSY_BIT   = 5;
    localparam logic [7:0]  VDPAO_CTRL_WMASK      = 8'h1b;

    // low data registers keep only their upper nibble
    localparam logic [7:0]  VDPAO_LOW_NIBBLE_MASK = 8'hf0;

    // =====================================================================
    // volume fields, reset values and the last period count
    localparam int unsigned VDPAO_PWM_VOL_TOP_BIT = 3;
    localparam logic [7:0]  VDPAO_REG_RESET       = 8'h00;
    localparam logic [11:0] VDPAO_PERIOD_LAST     = 12'hfff;

    // =====================================================================
    // types
    typedef enum logic [1:0] {
        VDPAO_IDLE  = 2'b00,
        VDPAO_RUN   = 2'b01,
        VDPAO_DRAIN = 2'b10
    } vdpao_state_t;

    typedef struct packed {
        logic        run;
        logic [11:0] duty;
        logic [3:0]  volume;
    } vdpao_pwm_cmd_t;

    typedef struct packed {
        logic pulse;
        logic active;
    } vdpao_pwm_stat_t;

endpackage

// *** vdpao_pwm_core.sv ***
// pwm period counter, duty latch and run/stop sequencing
`timescale 1ns/10ps
module vdpao_pwm_core
    import vdpao_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            reset,
    input  wire vdpao_pwm_cmd_t  cmd,
    output      vdpao_pwm_stat_t stat
);

    vdpao_state_t state_q, state_d;
    logic [11:0]  cnt_q, cnt_d;
    logic [11:0]  duty_q, duty_d;
    logic         run_prev_q;
    logic         run_rise;
    logic         run_fall;
    logic         period_end;
    logic [3:0]   vol_mult;
    logic [15:0]  vol_prod;
    logic [11:0]  eff_duty;

    // =====================================================================
    // next state
    always_comb begin
        run_rise   = cmd.run & ~run_prev_q;
        run_fall   = ~cmd.run & run_prev_q;
        period_end = (cnt_q == VDPAO_PERIOD_LAST);
        state_d    = state_q;
        duty_d     = duty_q;                                 // see [R13]
        cnt_d      = (state_q == VDPAO_IDLE) ? 12'h000 : 12'(cnt_q + 12'h001); // see [R16]
        unique case (state_q)
            VDPAO_IDLE: begin
                if (run_rise) begin
                    state_d = VDPAO_RUN;                     // see [R12]
                    duty_d  = cmd.duty;
                    cnt_d   = 12'h000;
                end
            end
            VDPAO_RUN: begin
                if (run_fall) begin
                    state_d = period_end ? VDPAO_IDLE : VDPAO_DRAIN; // see [R14]
                end
            end
            VDPAO_DRAIN: begin
                if (run_rise) begin
                    state_d = VDPAO_RUN;
                    duty_d  = cmd.duty;
                end else if (period_end) begin
                    state_d = VDPAO_IDLE;                    // see [R14]
                    cnt_d   = 12'h000;
                end
            end
            default: begin
                state_d = VDPAO_IDLE;
                cnt_d   = 12'h000;
            end
        endcase
    end

    // volume scales the high time: 1xxx full, else (v+1)/16 of the duty
    always_comb begin
        vol_mult = {1'b0, cmd.volume[2:0]} + 4'h1;
        vol_prod = 16'(duty_q) * 16'(vol_mult);
        eff_duty = cmd.volume[VDPAO_PWM_VOL_TOP_BIT] ? duty_q : vol_prod[15:4]; // see [R15]
        stat.active = (state_q != VDPAO_IDLE);
        stat.pulse  = stat.active && (cnt_q < eff_duty);    // see [R16]
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q    <= VDPAO_IDLE;
            cnt_q      <= 12'h000;
            duty_q     <= 12'h000;
            run_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            duty_q     <= duty_d;
            run_prev_q <= cmd.run;
        end
    end

    // =====================================================================
    // checks
    sequence run_start_s;
        (state_q == VDPAO_IDLE) && run_rise;
    endsequence

    sequence fall_mid_period_s;
        (state_q == VDPAO_RUN) && run_fall && !period_end;
    endsequence

    sequence drain_mid_s;
        (state_q == VDPAO_DRAIN) && !period_end && !run_rise;
    endsequence

    run_latch_a: assert property (@(posedge clk) disable iff (reset) // see [R12]
        run_start_s |=> (state_q == VDPAO_RUN) && (duty_q == $past(cmd.duty)))
        else $error("duty not latched on run rise");

    keep_duty_a: assert property (@(posedge clk) disable iff (reset) // see [R13]
        (state_q == VDPAO_RUN) |=> $stable(duty_q))
        else $error("duty changed while running");

    drain_stop_a: assert property (@(posedge clk) disable iff (reset) // see [R14]
        fall_mid_period_s |=> (state_q == VDPAO_DRAIN))
        else $error("stop did not wait for period end");

    // checked one cycle at a time, so a whole period never has to be unrolled
    drain_hold_a: assert property (@(posedge clk) disable iff (reset) // see [R14]
        drain_mid_s |=> (state_q == VDPAO_DRAIN))
        else $error("drain ended before period end");

    drain_end_a: assert property (@(posedge clk) disable iff (reset) // see [R14]
        (state_q == VDPAO_DRAIN) && period_end && !run_rise |=> (state_q == VDPAO_IDLE))
        else $error("generator kept running after drained period");

    count_step_a: assert property (@(posedge clk) disable iff (reset) // see [R16]
        (state_q == VDPAO_RUN) && !run_fall |=> cnt_q == 12'($past(cnt_q) + 12'h001))
        else $error("period counter did not advance");

    full_volume_a: assert property (@(posedge clk) disable iff (reset) // see [R15]
        stat.active && cmd.volume[VDPAO_PWM_VOL_TOP_BIT] && (cnt_q < duty_q) |-> stat.pulse)
        else $error("loudest volume lost high time");

endmodule // vdpao_pwm_core

// *** vdpao_speaker_model.sv ***
// speaker load model: counts pulse cycles on each pin and flags overlap
`timescale 1ns/10ps
module vdpao_speaker_model (
    input  wire logic        clk,
    input  wire logic        pin_first,
    input  wire logic        pin_second,
    output      logic [31:0] high_first,
    output      logic [31:0] high_second,
    output      logic [31:0] overlap
);
    // =====================================================================
    // pulse counters
    // both ends high would short the bridge, so that is counted as a fault
    initial begin
        high_first  = 32'h0;
        high_second = 32'h0;
        overlap     = 32'h0;
    end

    always @(posedge clk) begin
        if (pin_first === 1'b1) high_first <= high_first + 32'h1;
        if (pin_second === 1'b1) high_second <= high_second + 32'h1;
        if (pin_first === 1'b1 && pin_second === 1'b1) overlap <= overlap + 32'h1;
    end
endmodule // vdpao_speaker_model

// *** tb_top.sv ***
// self-checking testbench for the dac and pwm audio output block
`timescale 1ns/10ps
module tb_top;
    import vdpao_pkg::*;

    logic        core_clk, reset, wr, rd, rd_taken;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [11:0] dac_level, duty, sample;
    logic        dac_valid, spk_first, spk_second;
    logic [31:0] high_first, high_second, overlap, f0, s0, eff;
    int          miscompares, n_checks, cycles;
    logic [7:0]  exp_q[$];
    logic [7:0]  case_ctrl[5] = '{8'h01, 8'h11, 8'h19, 8'h01, 8'h01};
    logic [3:0]  case_vol[5]  = '{4'h8, 4'hf, 4'h3, 4'h0, 4'h8};
    logic        case_load[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    vdpao_top u_dut (
        .CORE_CLK           (core_clk),
        .RESET              (reset),
        .ADDR               (addr),
        .WDATA              (wdata),
        .WR                 (wr),
        .RD                 (rd),
        .RDATA              (rdata),
        .DAC_LEVEL          (dac_level),
        .DAC_VALID          (dac_valid),
        .SPEAKER_OUT_FIRST  (spk_first),
        .SPEAKER_OUT_SECOND (spk_second)
    );

    vdpao_speaker_model u_spk (
        .clk         (core_clk),
        .pin_first   (spk_first),
        .pin_second  (spk_second),
        .high_first  (high_first),
        .high_second (high_second),
        .overlap     (overlap)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // =====================================================================
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // =====================================================================
    // register bus; one idle cycle after each strobe keeps drivers single
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk) rd_taken <= rd;
    always @(negedge core_clk) begin
        if (rd_taken === 1'b1) begin
            if (exp_q.size() == 0) check(32'hdead, 32'h0);
            else check(32'(rdata), 32'(exp_q.pop_front()));
        end
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            summarize();
        end
    end

    // =====================================================================
    // pwm: one full period is counted on each pin, then a stop is drained
    task automatic pwm_case(input logic [7:0] ctrl, input logic [3:0] volume_setting, input logic load);
        if (load) duty = 12'($urandom);
        eff = volume_setting[3] ? 32'(duty) : (32'(duty) * (32'(volume_setting[2:0]) + 32'h1)) >> 4;
        wr_reg(VDPAO_OFF_VOLUME, {4'($urandom), volume_setting});
        if (load) begin
            wr_reg(VDPAO_OFF_PWM_LOW, {duty[3:0], 4'($urandom)});
            wr_reg(VDPAO_OFF_PWM_HIGH, duty[11:4]);
        end
        wr_reg(VDPAO_OFF_CTRL, ctrl);
        idle(8);
        f0 = high_first;
        s0 = high_second;
        idle(4096);
        // single-ended wins over sign: only the first pin may pulse then
        check(high_first - f0, (ctrl[3] || !ctrl[4]) ? eff : 32'h0);
        check(high_second - s0, (!ctrl[3] && ctrl[4]) ? eff : 32'h0);
        wr_reg(VDPAO_OFF_CTRL, ctrl & 8'hfe);
        rd_reg(VDPAO_OFF_CTRL, (ctrl & 8'hfe) | 8'h20);
        idle(4100);
        rd_reg(VDPAO_OFF_CTRL, ctrl & 8'hfe);
        check(32'({spk_first, spk_second}), 32'h0);
    endtask

    // =====================================================================
    // main sequence
    initial begin
        reset       = 1'b1;
        wr          = 1'b0;
        rd          = 1'b0;
        addr        = 3'h0;
        wdata       = 8'h00;
        rd_taken    = 1'b0;
        duty        = 12'h000;
        miscompares = 0;
        n_checks    = 0;
        cycles      = 0;
        void'($urandom(32'h25be5331));
        idle(3);
        reset <= 1'b0;
        idle(2);
        check(32'({spk_first, spk_second}), 32'h0);
        for (int a = 0; a < 6; a++) rd_reg(3'(a), VDPAO_REG_RESET);
        wr_reg(3'h6, 8'h5a);
        rd_reg(3'h6, 8'h00);
        rd_reg(3'h7, 8'h00);

        sample = 12'($urandom);
        wr_reg(VDPAO_OFF_DAC_LOW, {sample[3:0], 4'($urandom)});
        wr_reg(VDPAO_OFF_DAC_HIGH, sample[11:4]);
        rd_reg(VDPAO_OFF_DAC_LOW, {sample[3:0], 4'h0});
        rd_reg(VDPAO_OFF_DAC_HIGH, sample[11:4]);
        wr_reg(VDPAO_OFF_CTRL, 8'he6);
        rd_reg(VDPAO_OFF_CTRL, 8'h02);
        for (int v = 0; v < 8; v++) begin
            wr_reg(VDPAO_OFF_VOLUME, {5'($urandom), 3'(v)});
            idle(2);
            check(32'(dac_level), (32'(sample) * 32'(v + 1)) >> 3);
            check(32'(dac_valid), 32'h1);
        end
        wr_reg(VDPAO_OFF_CTRL, 8'h00);
        idle(2);
        check(32'({dac_valid, dac_level}), 32'h0);
        check(32'({spk_first, spk_second}), 32'h0);

        for (int i = 0; i < 5; i++) pwm_case(case_ctrl[i], case_vol[i], case_load[i]);
        check(overlap, 32'h0);
        summarize();
    end
endmodule // tb_top
